// ==== src/dag_consts.svh ====
`ifndef DAG_CONSTS_SVH
`define DAG_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// widths and counts
`define DAG_ADDR_W       12
`define DAG_BANK_W       4
`define DAG_BYTE_W       8
`define DAG_WORD_W       16
`define DAG_TARGET_W     20
`define DAG_PTR_CNT      3

////////////////////////////////////////////////////////////////////////////////
// opcode field positions
`define DAG_BIT_BANK     8
`define DAG_BIT_DEST     9

////////////////////////////////////////////////////////////////////////////////
// quick bank split: low part maps to the bottom, high part to special registers
`define DAG_QB_SPLIT     8'h60
`define DAG_QB_LOW_PAGE  4'h0
`define DAG_QB_HIGH_PAGE 4'hF

////////////////////////////////////////////////////////////////////////////////
// special register map
`define DAG_ALIAS_BASE   12'hF90
`define DAG_ALIAS_END    12'hFA8
`define DAG_OFS_PLAIN    3'h0
`define DAG_OFS_POSTINC  3'h1
`define DAG_OFS_POSTDEC  3'h2
`define DAG_OFS_PREINC   3'h3
`define DAG_OFS_PLUSW    3'h4
`define DAG_OFS_LO       3'h5
`define DAG_OFS_HI       3'h6
`define DAG_BANK_ADDR    12'hFB8
`define DAG_STAT_LO_ADDR 12'hFB9
`define DAG_STAT_HI_ADDR 12'hFBA

////////////////////////////////////////////////////////////////////////////////
// indexed literal offset
`define DAG_IDX_PTR      2'h2
`define DAG_IDX_LIMIT    8'h5F

////////////////////////////////////////////////////////////////////////////////
// reset values and adjust steps
`define DAG_BANK_RST     4'h0
`define DAG_PTR_RST      12'h000
`define DAG_STEP_UP      12'h001
`define DAG_STEP_DOWN    12'hFFF

`endif

// ==== src/dag_pkg.sv ====
`include "dag_consts.svh"

package dag_pkg;

	typedef enum logic [2:0]
	{
		DAG_M_INHERENT = 3'b000,
		DAG_M_LITERAL  = 3'b001,
		DAG_M_DIRECT   = 3'b010,
		DAG_M_MOVE     = 3'b011,
		DAG_M_JUMP     = 3'b100
	} dag_mode_t;

	typedef struct packed
	{
		logic       hit;
		logic [1:0] sel;
		logic [2:0] ofs;
	} dag_alias_t;

	typedef struct packed
	{
		logic [`DAG_PTR_CNT-1:0][`DAG_ADDR_W-1:0] ptr;
	} dag_ptr_state_t;

	typedef struct packed
	{
		logic                     res_valid;
		dag_mode_t                mode;
		logic [`DAG_ADDR_W-1:0]   addr;
		logic                     addr_used;
		logic                     indirect;
		logic                     dest_w;
		logic                     dest_reg;
		logic [`DAG_BYTE_W-1:0]   literal;
		logic [`DAG_TARGET_W-1:0] target;
		logic [`DAG_BANK_W-1:0]   bank;
		logic [`DAG_BYTE_W-1:0]   rdata;
	} dag_state_t;

	// special register address to pointer alias slot
	function automatic dag_alias_t dag_alias_decode(input logic [`DAG_ADDR_W-1:0] a);
		dag_alias_t r;
		logic [`DAG_ADDR_W-1:0] rel;
		rel   = a - `DAG_ALIAS_BASE;
		r.hit = (a >= `DAG_ALIAS_BASE) && (a < `DAG_ALIAS_END);
		r.sel = rel[4:3];
		r.ofs = rel[2:0];
		return r;
	endfunction

endpackage

// ==== src/dag_ptr_if.sv ====
`timescale 1ns/100ps
`include "dag_consts.svh"

interface dag_ptr_if;
	logic                                     adj_valid;
	logic [1:0]                               adj_sel;
	logic [`DAG_ADDR_W-1:0]                   adj_delta;
	logic                                     wr_en;
	logic [1:0]                               wr_sel;
	logic                                     wr_hi;
	logic [`DAG_BYTE_W-1:0]                   wr_data;
	logic [`DAG_PTR_CNT-1:0][`DAG_ADDR_W-1:0] ptr;

	modport ctrl
	(
		output adj_valid, adj_sel, adj_delta, wr_en, wr_sel, wr_hi, wr_data,
		input  ptr
	);

	modport store
	(
		input  adj_valid, adj_sel, adj_delta, wr_en, wr_sel, wr_hi, wr_data,
		output ptr
	);
endinterface

// ==== src/dag_ptr_file.sv ====
`timescale 1ns/100ps
`include "dag_consts.svh"

module dag_ptr_file
	import dag_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	dag_ptr_if.store pif
);

	dag_ptr_state_t s;
	dag_ptr_state_t next_s;

	always_comb
	begin
		next_s = s;
		for (int i = 0; i < `DAG_PTR_CNT; i++)
		begin
			if (pif.adj_valid && (pif.adj_sel == 2'(i)))
				next_s.ptr[i] = s.ptr[i] + pif.adj_delta; // [RULE12] [RULE14]
			// direct write of one half wins over an adjust
			if (pif.wr_en && (pif.wr_sel == 2'(i)))
			begin
				next_s.ptr[i] = s.ptr[i];
				if (pif.wr_hi)
					next_s.ptr[i][11:8] = pif.wr_data[3:0]; // [RULE11] [RULE14]
				else
					next_s.ptr[i][7:0] = pif.wr_data; // [RULE11]
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			s <= '{ptr: {`DAG_PTR_CNT{`DAG_PTR_RST}}};
		else
			s <= next_s;
	end

	assign pif.ptr = s.ptr;

endmodule // dag_ptr_file

// ==== src/dag_addr_gen.sv ====
// Functional notes
// RULE1: inherent instructions carry no operand; global or one fixed register.
// RULE2: literal operand comes from opcode; jumps carry a 20-bit program target.
// RULE3: byte and bit instructions default to direct, 8-bit address in low byte.
// RULE4: bank flag 1 joins bank select value and 8-bit address into 12 bits.
// RULE5: bank flag 0 ignores bank select value and maps into the quick bank.
// RULE6: full address move takes whole 12-bit address, bank select value ignored.
// RULE7: result-target flag 1 writes result back into the source register.
// RULE8: result-target flag 0 writes result to accumulator, source untouched.
// RULE9: without result-target flag, destination is fixed by the opcode.
// RULE10: indirect mode takes the address from a pointer, for reads and writes.
// RULE11: pointers are special registers, directly readable and writable.
// RULE12: alias access adjusts pointer: increment, decrement, or offset.
// RULE13: extended set enable adds indexed literal offset addressing.
// RULE14: pointer is 12 bits, 4-bit high and 8-bit low, adjusts carry across.
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`include "dag_consts.svh"

module dag_addr_gen
	import dag_pkg::*;
(
	input  wire logic                     clk,
	input  wire logic                     reset_n,
	input  wire logic                     req_valid,
	input  wire dag_mode_t                req_mode,
	input  wire logic [`DAG_WORD_W-1:0]   req_word,
	input  wire logic [`DAG_TARGET_W-1:0] req_ext,
	input  wire logic                     req_has_dest,
	input  wire logic                     req_implicit_w,
	input  wire logic [`DAG_BYTE_W-1:0]   w_value,
	input  wire logic                     ext_set_enable,
	input  wire logic [`DAG_ADDR_W-1:0]   port_addr,
	input  wire logic [`DAG_BYTE_W-1:0]   port_wdata,
	input  wire logic                     port_wr,
	input  wire logic                     port_rd,
	output logic [`DAG_BYTE_W-1:0]        port_rdata,
	output logic                          res_valid,
	output dag_mode_t                     res_mode,
	output logic [`DAG_ADDR_W-1:0]        res_addr,
	output logic                          res_addr_used,
	output logic                          res_indirect,
	output logic                          res_dest_w,
	output logic                          res_dest_reg,
	output logic [`DAG_BYTE_W-1:0]        res_literal,
	output logic [`DAG_TARGET_W-1:0]      res_target,
	output logic [`DAG_BANK_W-1:0]        bank_select_value
);

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	// 8-bit address into the shared quick bank
	function automatic logic [`DAG_ADDR_W-1:0] quick_map(input logic [`DAG_BYTE_W-1:0] a8);
		if (a8 < `DAG_QB_SPLIT)
			return {`DAG_QB_LOW_PAGE, a8};
		else
			return {`DAG_QB_HIGH_PAGE, a8};
	endfunction

	// accumulator as a signed offset
	function automatic logic [`DAG_ADDR_W-1:0] sext_byte(input logic [`DAG_BYTE_W-1:0] b);
		return {{(`DAG_ADDR_W-`DAG_BYTE_W){b[`DAG_BYTE_W-1]}}, b};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// pointer store

	dag_ptr_if pif ();

	dag_ptr_file u_ptr_file
	(
		.clk     (clk),
		.reset_n (reset_n),
		.pif     (pif.store)
	);

	////////////////////////////////////////////////////////////////////////////////
	// state

	dag_state_t s;
	dag_state_t next_s;

	logic [`DAG_BYTE_W-1:0]   op_addr8;
	logic                     op_bank;
	logic                     op_dest;
	logic [`DAG_ADDR_W-1:0]   cand_addr;
	logic                     cand_used;
	logic [`DAG_ADDR_W-1:0]   idx_base;
	logic                     idx_hit;
	dag_alias_t               req_alias;
	dag_alias_t               port_alias;
	logic [`DAG_ADDR_W-1:0]   sel_ptr;
	logic [`DAG_ADDR_W-1:0]   port_ptr;

	assign op_addr8 = req_word[`DAG_BYTE_W-1:0];
	assign op_bank  = req_word[`DAG_BIT_BANK];
	assign op_dest  = req_word[`DAG_BIT_DEST];
	assign idx_base = pif.ptr[`DAG_IDX_PTR];
	// indexed offset: only direct mode with quick bank flag and a small address
	assign idx_hit  = ext_set_enable && !op_bank && (op_addr8 <= `DAG_IDX_LIMIT);

	////////////////////////////////////////////////////////////////////////////////
	// operand address formation

	always_comb
	begin
		cand_addr = '0;
		cand_used = 1'b0;
		case (req_mode)
			DAG_M_DIRECT:
			begin
				cand_used = 1'b1;
				if (idx_hit)
					cand_addr = idx_base + {4'h0, op_addr8}; // [RULE13]
				else if (op_bank)
					cand_addr = {s.bank, op_addr8}; // [RULE3] [RULE4]
				else
					cand_addr = quick_map(op_addr8); // [RULE5]
			end
			DAG_M_MOVE:
			begin
				cand_used = 1'b1;
				cand_addr = req_ext[`DAG_ADDR_W-1:0]; // [RULE6]
			end
			default:
			begin
				cand_used = 1'b0;
				cand_addr = '0;
			end
		endcase
	end

	assign req_alias = dag_alias_decode(cand_addr);
	assign sel_ptr   = pif.ptr[req_alias.sel];

	////////////////////////////////////////////////////////////////////////////////
	// register port decode

	assign port_alias = dag_alias_decode(port_addr);
	assign port_ptr   = pif.ptr[port_alias.sel];

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb
	begin
		next_s           = s;
		next_s.res_valid = 1'b0;
		next_s.rdata     = '0;
		pif.adj_valid    = 1'b0;
		pif.adj_sel      = '0;
		pif.adj_delta    = '0;
		pif.wr_en        = 1'b0;
		pif.wr_sel       = '0;
		pif.wr_hi        = 1'b0;
		pif.wr_data      = '0;

		// register writes
		if (port_wr)
		begin
			if (port_addr == `DAG_BANK_ADDR)
				next_s.bank = port_wdata[`DAG_BANK_W-1:0];
			else if (port_alias.hit && (port_alias.ofs == `DAG_OFS_LO))
			begin
				pif.wr_en   = 1'b1; // [RULE11]
				pif.wr_sel  = port_alias.sel;
				pif.wr_data = port_wdata;
			end
			else if (port_alias.hit && (port_alias.ofs == `DAG_OFS_HI))
			begin
				pif.wr_en   = 1'b1; // [RULE11] [RULE14]
				pif.wr_sel  = port_alias.sel;
				pif.wr_hi   = 1'b1;
				pif.wr_data = port_wdata;
			end
		end

		// register reads, valid one cycle later only
		if (port_rd)
		begin
			if (port_addr == `DAG_BANK_ADDR)
				next_s.rdata = {4'h0, s.bank};
			else if (port_addr == `DAG_STAT_LO_ADDR)
				next_s.rdata = s.addr[7:0];
			else if (port_addr == `DAG_STAT_HI_ADDR)
				next_s.rdata = {s.indirect, s.mode, s.addr[11:8]};
			else if (port_alias.hit && (port_alias.ofs == `DAG_OFS_LO))
				next_s.rdata = port_ptr[7:0]; // [RULE11]
			else if (port_alias.hit && (port_alias.ofs == `DAG_OFS_HI))
				next_s.rdata = {4'h0, port_ptr[11:8]}; // [RULE11] [RULE14]
			else
				next_s.rdata = '0;
		end

		// instruction request
		if (req_valid)
		begin
			next_s.res_valid = 1'b1;
			next_s.mode      = req_mode;
			next_s.addr_used = cand_used;
			next_s.addr      = cand_addr;
			next_s.indirect  = 1'b0;
			next_s.literal   = '0;
			next_s.target    = '0;
			next_s.dest_w    = 1'b0;
			next_s.dest_reg  = 1'b0;
			case (req_mode)
				DAG_M_INHERENT:
				begin
					next_s.addr_used = 1'b0; // [RULE1]
					next_s.dest_w    = req_implicit_w; // [RULE9]
					next_s.dest_reg  = 1'b0;
				end
				DAG_M_LITERAL:
				begin
					next_s.literal = op_addr8; // [RULE2]
					next_s.dest_w  = 1'b1;
				end
				DAG_M_JUMP:
				begin
					next_s.target = req_ext; // [RULE2]
				end
				DAG_M_MOVE:
				begin
					next_s.dest_reg = 1'b1; // [RULE6]
				end
				DAG_M_DIRECT:
				begin
					next_s.indirect = idx_hit; // [RULE13]
					if (req_has_dest)
					begin
						next_s.dest_reg = op_dest; // [RULE7]
						next_s.dest_w   = !op_dest; // [RULE8]
					end
					else
					begin
						next_s.dest_w   = req_implicit_w; // [RULE9]
						next_s.dest_reg = !req_implicit_w; // [RULE9]
					end
				end
				default:
				begin
					next_s.addr_used = 1'b0;
				end
			endcase

			// pointer aliases turn a direct or move address into an indirect one
			if (cand_used && req_alias.hit && (req_alias.ofs <= `DAG_OFS_PLUSW))
			begin
				next_s.indirect = 1'b1; // [RULE10]
				next_s.addr     = sel_ptr; // [RULE10]
				pif.adj_sel     = req_alias.sel;
				case (req_alias.ofs)
					`DAG_OFS_POSTINC:
					begin
						pif.adj_valid = 1'b1; // [RULE12]
						pif.adj_delta = `DAG_STEP_UP;
					end
					`DAG_OFS_POSTDEC:
					begin
						pif.adj_valid = 1'b1; // [RULE12]
						pif.adj_delta = `DAG_STEP_DOWN;
					end
					`DAG_OFS_PREINC:
					begin
						next_s.addr   = sel_ptr + `DAG_STEP_UP; // [RULE12] [RULE14]
						pif.adj_valid = 1'b1;
						pif.adj_delta = `DAG_STEP_UP;
					end
					`DAG_OFS_PLUSW:
					begin
						next_s.addr = sel_ptr + sext_byte(w_value); // [RULE12]
					end
					default:
					begin
						next_s.addr = sel_ptr;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s <= '{res_valid: 1'b0, mode: DAG_M_INHERENT, addr: '0, addr_used: 1'b0,
			       indirect: 1'b0, dest_w: 1'b0, dest_reg: 1'b0, literal: '0,
			       target: '0, bank: `DAG_BANK_RST, rdata: '0};
		end
		else
		begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign port_rdata        = s.rdata;
	assign res_valid         = s.res_valid;
	assign res_mode          = s.mode;
	assign res_addr          = s.addr;
	assign res_addr_used     = s.addr_used;
	assign res_indirect      = s.indirect;
	assign res_dest_w        = s.dest_w;
	assign res_dest_reg      = s.dest_reg;
	assign res_literal       = s.literal;
	assign res_target        = s.target;
	assign bank_select_value = s.bank;

endmodule // dag_addr_gen

// ==== test/dag_addr_gen_props.sv ====
`timescale 1ns/100ps
`include "dag_consts.svh"

module dag_addr_gen_props
	import dag_pkg::*;
(
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        req_valid,
	input wire dag_mode_t   req_mode,
	input wire logic [15:0] req_word,
	input wire logic [19:0] req_ext,
	input wire logic        req_has_dest,
	input wire logic        req_implicit_w,
	input wire logic        ext_set_enable,
	input wire logic        port_rd,
	input wire logic [7:0]  port_rdata,
	input wire logic        res_valid,
	input wire logic [11:0] res_addr,
	input wire logic        res_addr_used,
	input wire logic        res_indirect,
	input wire logic        res_dest_w,
	input wire logic        res_dest_reg,
	input wire logic [7:0]  res_literal,
	input wire logic [19:0] res_target,
	input wire logic [3:0]  bank_select_value
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	sequence s_dir;
		req_valid && req_mode == DAG_M_DIRECT;
	endsequence
	sequence s_alias;
		req_valid && req_mode == DAG_M_MOVE && req_ext[11:0] >= 12'hF90 && req_ext[11:0] < 12'hFA8
			&& req_ext[2:0] < 3'h5;
	endsequence

	a_valid_pulse: assert property (res_valid == $past(req_valid))
		else $error("result strobe not one cycle after request");
	a_inherent_noaddr: assert property (req_valid && req_mode == DAG_M_INHERENT |=>
		!res_addr_used && !res_dest_reg && res_dest_w == $past(req_implicit_w))
		else $error("inherent request wrong");
	a_literal_opcode: assert property (req_valid && req_mode == DAG_M_LITERAL |=>
		res_literal == $past(req_word[7:0]) && res_dest_w)
		else $error("literal not from opcode");
	a_jump_target: assert property (req_valid && req_mode == DAG_M_JUMP |=>
		res_target == $past(req_ext) && !res_dest_w && !res_dest_reg)
		else $error("jump target wrong");
	a_bank_joined: assert property (s_dir and req_word[8] && bank_select_value != 4'hF |=>
		res_addr == {$past(bank_select_value), $past(req_word[7:0])} && res_addr_used)
		else $error("banked address wrong");
	a_quick_bank: assert property (s_dir and !req_word[8] && !ext_set_enable && req_word[7:0] < 8'h60 |=>
		res_addr == {4'h0, $past(req_word[7:0])})
		else $error("quick bank address wrong");
	a_move_full: assert property (req_valid && req_mode == DAG_M_MOVE && req_ext[11:8] != 4'hF |=>
		res_addr == $past(req_ext[11:0]) && res_dest_reg && !res_indirect)
		else $error("full move address wrong");
	a_dest_flag: assert property (s_dir and req_has_dest |=>
		res_dest_reg == $past(req_word[9]) && res_dest_w != res_dest_reg)
		else $error("flagged destination wrong");
	a_dest_implicit: assert property (s_dir and !req_has_dest |=>
		res_dest_w == $past(req_implicit_w) && res_dest_reg != res_dest_w)
		else $error("implicit destination wrong");
	a_alias_indirect: assert property (s_alias |=> res_indirect && res_addr_used)
		else $error("alias access not indirect");
	a_read_stands: assert property (!$past(port_rd) |-> port_rdata == 8'h00)
		else $error("read data outside its cycle");
	a_indexed_mode: assert property (s_dir and !req_word[8] && ext_set_enable && req_word[7:0] <= 8'h5F |=>
		res_indirect)
		else $error("indexed offset not from pointer");
endmodule // dag_addr_gen_props

bind dag_addr_gen dag_addr_gen_props chk
(
	.clk               (clk),
	.reset_n           (reset_n),
	.req_valid         (req_valid),
	.req_mode          (req_mode),
	.req_word          (req_word),
	.req_ext           (req_ext),
	.req_has_dest      (req_has_dest),
	.req_implicit_w    (req_implicit_w),
	.ext_set_enable    (ext_set_enable),
	.port_rd           (port_rd),
	.port_rdata        (port_rdata),
	.res_valid         (res_valid),
	.res_addr          (res_addr),
	.res_addr_used     (res_addr_used),
	.res_indirect      (res_indirect),
	.res_dest_w        (res_dest_w),
	.res_dest_reg      (res_dest_reg),
	.res_literal       (res_literal),
	.res_target        (res_target),
	.bank_select_value (bank_select_value)
);

// ==== test/dag_data_mem.sv ====
`timescale 1ns/100ps

module dag_data_mem
(
	input wire logic        clk,
	input wire logic        res_valid,
	input wire logic        res_dest_reg,
	input wire logic [11:0] res_addr,
	input wire logic [7:0]  w_value,
	output logic [7:0]      rd_data
);
	logic [7:0] mem [4096];

	// write-back into the addressed register
	always_ff @(posedge clk)
		if (res_valid && res_dest_reg)
			mem[res_addr] <= w_value;
	assign rd_data = mem[res_addr];
endmodule // dag_data_mem

// ==== test/data_operand_address_gen_tb.sv ====
`timescale 1ns/100ps
`include "dag_consts.svh"

module data_operand_address_gen_tb
	import dag_pkg::*;
;
	logic        clk, reset_n, req_valid, req_has_dest, req_implicit_w, ext_set_enable;
	logic        port_wr, port_rd, res_valid, res_addr_used, res_indirect, res_dest_w, res_dest_reg;
	dag_mode_t   req_mode, res_mode;
	logic [15:0] req_word;
	logic [19:0] req_ext, res_target;
	logic [11:0] port_addr, res_addr;
	logic [7:0]  w_value, port_wdata, port_rdata, res_literal;
	logic [3:0]  bank_select_value;
	int          num_errors, checks, bank;
	int          ptr [3];

	dag_addr_gen uut
	(
		.clk               (clk),
		.reset_n           (reset_n),
		.req_valid         (req_valid),
		.req_mode          (req_mode),
		.req_word          (req_word),
		.req_ext           (req_ext),
		.req_has_dest      (req_has_dest),
		.req_implicit_w    (req_implicit_w),
		.w_value           (w_value),
		.ext_set_enable    (ext_set_enable),
		.port_addr         (port_addr),
		.port_wdata        (port_wdata),
		.port_wr           (port_wr),
		.port_rd           (port_rd),
		.port_rdata        (port_rdata),
		.res_valid         (res_valid),
		.res_mode          (res_mode),
		.res_addr          (res_addr),
		.res_addr_used     (res_addr_used),
		.res_indirect      (res_indirect),
		.res_dest_w        (res_dest_w),
		.res_dest_reg      (res_dest_reg),
		.res_literal       (res_literal),
		.res_target        (res_target),
		.bank_select_value (bank_select_value)
	);
	dag_data_mem mem_i (.clk(clk), .res_valid(res_valid), .res_dest_reg(res_dest_reg), .res_addr(res_addr),
		.w_value(w_value), .rd_data());

	////////////////////////////////////////////////////////////////////////////
	task chk(input logic [19:0] g, input logic [19:0] e);
		checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		port_wr <= 1'b1;
		port_addr <= a;
		port_wdata <= d;
		@(posedge clk);
		port_wr <= 1'b0;
	endtask

	task rd(input logic [11:0] a, input logic [7:0] e);
		@(posedge clk);
		port_rd <= 1'b1;
		port_addr <= a;
		@(posedge clk);
		port_rd <= 1'b0;
		#1;
		chk(port_rdata, e);
	endtask

	task req(input dag_mode_t m, input logic [15:0] w, input logic [19:0] e, input logic hd, iw,
		input logic [7:0] v);
		int a, n, o, ind;
		logic [1:0] dd;
		@(posedge clk);
		ind = 0;
		a = m == DAG_M_MOVE ? e[11:0] : w[8] ? bank * 256 + w[7:0] : w[7:0] < 'h60 ? w[7:0] : 'hF00 + w[7:0];
		if (m == DAG_M_DIRECT && ext_set_enable && !w[8] && w[7:0] <= 'h5F)
		begin
			a = (ptr[2] + w[7:0]) & 'hFFF;
			ind = 1;
		end
		n = (a - 'hF90) / 8;
		o = a % 8;
		if (m inside {DAG_M_DIRECT, DAG_M_MOVE} && a >= 'hF90 && a < 'hFA8 && o < 5)
		begin
			ind = 1;
			a = (ptr[n] + (o == 3) + (o == 4 ? int'($signed(v)) : 0)) & 'hFFF;
			ptr[n] = (ptr[n] + (o == 1 || o == 3) - (o == 2)) & 'hFFF;
		end
		dd = m == DAG_M_DIRECT ? (hd ? {!w[9], w[9]} : {iw, !iw}) : m == DAG_M_INHERENT ? {iw, 1'b0}
			: m == DAG_M_LITERAL ? 2'b10 : m == DAG_M_MOVE ? 2'b01 : 2'b00;
		req_valid <= 1'b1;
		req_mode <= m;
		req_word <= w;
		req_ext <= e;
		req_has_dest <= hd;
		req_implicit_w <= iw;
		w_value <= v;
		@(posedge clk);
		req_valid <= 1'b0;
		#1;
		chk(res_valid, 1);
		chk(res_mode, m);
		chk(res_addr_used, m inside {DAG_M_DIRECT, DAG_M_MOVE});
		if (m inside {DAG_M_DIRECT, DAG_M_MOVE})
		begin
			chk(res_addr, a);
			chk(res_indirect, ind);
		end
		chk(res_literal, m == DAG_M_LITERAL ? w[7:0] : 0);
		chk(res_target, m == DAG_M_JUMP ? e : 0);
		chk({res_dest_w, res_dest_reg}, dd);
	endtask

	task results();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial
	begin
		#2000000;
		num_errors++;
		results();
	end

	initial
	begin
		{reset_n, req_valid, req_has_dest, req_implicit_w, ext_set_enable, port_wr, port_rd} = '0;
		{req_word, req_ext, port_addr, w_value, port_wdata} = '0;
		req_mode = DAG_M_INHERENT;
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		void'($urandom(12));
		rd(12'hFB8, 8'h00);
		rd(12'hFC0, 8'h00);
		for (int i = 0; i < 80; i++)
		begin
			if (i % 10 == 0)
			begin
				bank = $urandom % 16;
				wr(12'hFB8, bank[7:0]);
				rd(12'hFB8, bank[7:0]);
			end
			req(dag_mode_t'(i % 5), $urandom, $urandom, $urandom, $urandom, $urandom);
		end
		$display("random decode done");
		for (int n = 0; n < 3; n++)
		begin
			wr(12'hF95 + 8 * n, 8'hFF);
			wr(12'hF96 + 8 * n, 8'h01);
			ptr[n] = 'h1FF;
			for (int o = 1; o < 6; o++)
			begin
				req(DAG_M_DIRECT, 16'h90 + 8 * n + o % 5, 0, 0, 0, $urandom);
				rd(12'hF95 + 8 * n, ptr[n] % 256);
				rd(12'hF96 + 8 * n, ptr[n] / 256);
			end
		end
		$display("pointer aliases done");
		ext_set_enable <= 1'b1;
		req(DAG_M_DIRECT, 16'h005F, 0, 1, 0, 8'h00);
		req(DAG_M_DIRECT, 16'h0060, 0, 0, 1, 8'h00);
		req(DAG_M_DIRECT, 16'h0310, 0, 1, 0, 8'h00);
		req(DAG_M_MOVE, 16'h0000, 20'h00FA1, 0, 0, 8'h00);
		ext_set_enable <= 1'b0;
		$display("extended mode done");
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		bank = 0;
		ptr = '{0, 0, 0};
		rd(12'hFB8, 8'h00);
		rd(12'hFA5, 8'h00);
		$display("second reset done");
		results();
	end
endmodule // data_operand_address_gen_tb
